// file: verilog/odl_params.svh
// Purpose: constants of the octal converter serial loader
// Assumes: 11-bit words, msb first, eight 8-bit channel latches
// Notes:   definitions only
`ifndef ODL_PARAMS_SVH
`define ODL_PARAMS_SVH

`define ODL_WORD_W      11
`define ODL_CODE_W      8
`define ODL_ADDR_W      3
`define ODL_NUM_CH      8
`define ODL_ADDR_MSB    10
`define ODL_ADDR_LSB    8
`define ODL_CODE_MSB    7
`define ODL_CODE_LSB    0
`define ODL_MIDSCALE    8'h80
`define ODL_FULL_SPAN   256
`define ODL_SYNC_IDLE   3'h7

`endif

// file: verilog/odl_pkg.sv
// Purpose: shared types of the octal converter serial loader
// Assumes: constants come from odl_params.svh
// Notes:   types only
`include "odl_params.svh"
package odl_pkg;

   typedef logic [`ODL_CODE_W-1:0] odl_code_t;
   typedef logic [`ODL_ADDR_W-1:0] odl_addr_t;

   // one decoded word as it leaves the link domain
   typedef struct packed
   {
      odl_addr_t chan_addr;
      odl_code_t code;
   } odl_word_t;

   typedef enum logic [1:0]
   {
      ODL_IDLE  = 2'b00,
      ODL_WAIT  = 2'b01,
      ODL_APPLY = 2'b10
   } odl_state_t;

endpackage

// file: verilog/odl_serial_shifter.sv
// Purpose: link-domain shift register of the serial loader
// Assumes: sclk is the host serial clock, stopped outside frames
// Notes:   word is captured on the load_select_n rise and flagged by a toggle
`timescale 1ns/100ps
`default_nettype none
`include "odl_params.svh"

module odl_serial_shifter
(
   input  wire logic              sclk,
   input  wire logic              nrst,
   input  wire logic              load_select_n,
   input  wire logic              serial_word_in,
   output var  odl_pkg::odl_word_t word_q,
   output var  logic              word_tgl_q
);

   // ************************************************
   // shift register
   // ************************************************
   logic [`ODL_WORD_W-1:0] shift_q; // RQ1
   logic [`ODL_WORD_W-1:0] shift_d;

   always_comb
   begin
      shift_d = shift_q;
      if (!load_select_n)
      begin
         shift_d = {shift_q[`ODL_WORD_W-2:0], serial_word_in}; // RQ11
      end
   end

   // older bits fall off the top, so only the last eleven survive
   always_ff @(posedge sclk or negedge nrst)
   begin
      if (!nrst)
      begin
         shift_q <= '0;
      end
      else
      begin
         shift_q <= shift_d; // RQ13
      end
   end

   // ************************************************
   // capture on select rise
   // ************************************************
   // sclk may be still at select rise, so the select edge itself clocks the hold
   odl_pkg::odl_word_t word_d;
   logic               word_tgl_d;

   always_comb
   begin
      word_d.chan_addr = shift_q[`ODL_ADDR_MSB:`ODL_ADDR_LSB]; // RQ2
      word_d.code      = shift_q[`ODL_CODE_MSB:`ODL_CODE_LSB]; // RQ2
      word_tgl_d       = ~word_tgl_q;
   end

   always_ff @(posedge load_select_n or negedge nrst)
   begin
      if (!nrst)
      begin
         word_q     <= '0;
         word_tgl_q <= 1'b0;
      end
      else
      begin
         word_q     <= word_d; // RQ12
         word_tgl_q <= word_tgl_d;
      end
   end

endmodule // odl_serial_shifter
`default_nettype wire

// file: verilog/odl_loader.sv
// Purpose: octal 8-bit converter latch loader behind a three-wire serial port
// Assumes: core_clk 125 MHz; link pins asynchronous to it
// Notes:   latch codes drive channel_output; power-down blanks but keeps codes
`timescale 1ns/100ps
`default_nettype none
`include "odl_params.svh"

//
// Contract
// RQ1: each channel update is one eleven-bit serial word.
// RQ2: word is msb first; three address bits then eight code bits.
// RQ3: target channel is address plus one; 000 is channel one.
// RQ4: channels written independently in any order; others untouched.
// RQ5: midscale reset input forces every latch to mid-scale.
// RQ6: mid-scale code is 128.
// RQ7: power-up reset places every latch at mid-scale.
// RQ8: power-down keeps all latch contents.
// RQ9: leaving power-down drives outputs from retained codes.
// RQ10: each channel holds an 8-bit code; output fraction is code over 256.
// RQ11: with select low each rising serial clock shifts one bit in.
// RQ12: select rise decodes address and loads code into that latch.
// RQ13: only the last eleven bits shifted are used.
// RQ14: power-down input low enters shutdown; reset and shutdown need no serial clock.
// RQ15: host completes at least eleven bits before raising select.
module odl_loader
(
   input  wire logic                   core_clk,
   input  wire logic                   nrst,
   input  wire logic                   sclk,
   input  wire logic                   load_select_n,
   input  wire logic                   serial_word_in,
   input  wire logic                   midscale_reset_n,
   input  wire logic                   power_down_n,
   output var  logic [`ODL_CODE_W*`ODL_NUM_CH-1:0] channel_latch,
   output var  logic [`ODL_CODE_W*`ODL_NUM_CH-1:0] channel_output,
   output var  logic                   powered_down,
   output var  logic [`ODL_NUM_CH-1:0] channel_updated
);

   // ************************************************
   // link domain
   // ************************************************
   odl_pkg::odl_word_t link_word;
   logic               link_tgl;

   odl_serial_shifter u_shift
   (
      .sclk           (sclk),
      .nrst           (nrst),
      .load_select_n  (load_select_n),
      .serial_word_in (serial_word_in),
      .word_q         (link_word),
      .word_tgl_q     (link_tgl)
   );

   // ************************************************
   // synchronisers
   // ************************************************
   // three stages; a change counts once stages two and three agree
   logic [2:0] tgl_sync_q;
   logic [2:0] rst_sync_q;
   logic [2:0] pd_sync_q;
   logic [2:0] tgl_sync_d;
   logic [2:0] rst_sync_d;
   logic [2:0] pd_sync_d;

   always_comb
   begin
      tgl_sync_d = {tgl_sync_q[1:0], link_tgl};
      rst_sync_d = {rst_sync_q[1:0], midscale_reset_n};
      pd_sync_d  = {pd_sync_q[1:0], power_down_n};
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tgl_sync_q <= '0;
         rst_sync_q <= `ODL_SYNC_IDLE;
         pd_sync_q  <= `ODL_SYNC_IDLE;
      end
      else
      begin
         tgl_sync_q <= tgl_sync_d;
         rst_sync_q <= rst_sync_d;
         pd_sync_q  <= pd_sync_d;
      end
   end

   // ************************************************
   // word acceptance
   // ************************************************
   // word bus is stable long before the toggle settles, so it is sampled directly
   odl_pkg::odl_state_t state_q;
   odl_pkg::odl_state_t state_d;
   logic                seen_tgl_q;
   logic                seen_tgl_d;
   logic                rst_lvl_q;
   logic                rst_lvl_d;
   logic                pd_lvl_q;
   logic                pd_lvl_d;
   odl_pkg::odl_word_t  held_q;
   odl_pkg::odl_word_t  held_d;

   always_comb
   begin
      state_d    = state_q;
      seen_tgl_d = seen_tgl_q;
      held_d     = held_q;
      rst_lvl_d  = rst_lvl_q;
      pd_lvl_d   = pd_lvl_q;
      if (rst_sync_q[2] == rst_sync_q[1])
      begin
         rst_lvl_d = rst_sync_q[2];
      end
      if (pd_sync_q[2] == pd_sync_q[1])
      begin
         pd_lvl_d = pd_sync_q[2];
      end
      case (state_q)
         odl_pkg::ODL_IDLE:
         begin
            if ((tgl_sync_q[2] == tgl_sync_q[1]) && (tgl_sync_q[2] != seen_tgl_q))
            begin
               seen_tgl_d = tgl_sync_q[2];
               state_d    = odl_pkg::ODL_WAIT;
            end
         end
         odl_pkg::ODL_WAIT:
         begin
            held_d  = link_word;
            state_d = odl_pkg::ODL_APPLY;
         end
         odl_pkg::ODL_APPLY:
         begin
            state_d = odl_pkg::ODL_IDLE;
         end
         default:
         begin
            state_d = odl_pkg::ODL_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q    <= odl_pkg::ODL_IDLE;
         seen_tgl_q <= 1'b0;
         held_q     <= '0;
         rst_lvl_q  <= 1'b1;
         pd_lvl_q   <= 1'b1;
      end
      else
      begin
         state_q    <= state_d;
         seen_tgl_q <= seen_tgl_d;
         held_q     <= held_d;
         rst_lvl_q  <= rst_lvl_d;
         pd_lvl_q   <= pd_lvl_d;
      end
   end

   // ************************************************
   // channel latches
   // ************************************************
   function automatic logic [`ODL_NUM_CH-1:0] chan_onehot(input odl_pkg::odl_addr_t a);
      chan_onehot = '0;
      chan_onehot[a] = 1'b1; // RQ3
   endfunction

   odl_pkg::odl_code_t    latch_q [`ODL_NUM_CH];
   odl_pkg::odl_code_t    latch_d [`ODL_NUM_CH];
   logic [`ODL_CODE_W*`ODL_NUM_CH-1:0] flat_latch_d;
   logic [`ODL_CODE_W*`ODL_NUM_CH-1:0] flat_out_d;
   logic [`ODL_NUM_CH-1:0] upd_d;

   always_comb
   begin
      upd_d = '0;
      if (state_q == odl_pkg::ODL_APPLY)
      begin
         upd_d = chan_onehot(held_q.chan_addr); // RQ12
      end
      for (int i = 0; i < `ODL_NUM_CH; i++)
      begin
         latch_d[i] = latch_q[i]; // RQ4 RQ8
         if (!rst_lvl_q)
         begin
            latch_d[i] = `ODL_MIDSCALE; // RQ5 RQ6
         end
         else if (upd_d[i])
         begin
            latch_d[i] = held_q.code; // RQ10
         end
         flat_latch_d[i*`ODL_CODE_W +: `ODL_CODE_W] = latch_d[i];
         // blanked while powered down, restored from the kept code after
         flat_out_d[i*`ODL_CODE_W +: `ODL_CODE_W] = pd_lvl_q ? latch_d[i] : '0; // RQ9 RQ14
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < `ODL_NUM_CH; i++)
         begin
            latch_q[i] <= `ODL_MIDSCALE; // RQ7
         end
         channel_latch   <= {`ODL_NUM_CH{`ODL_MIDSCALE}};
         channel_output  <= {`ODL_NUM_CH{`ODL_MIDSCALE}};
         powered_down    <= 1'b0;
         channel_updated <= '0;
      end
      else
      begin
         latch_q         <= latch_d;
         channel_latch   <= flat_latch_d;
         channel_output  <= flat_out_d;
         powered_down    <= ~pd_lvl_q; // RQ14
         channel_updated <= rst_lvl_q ? upd_d : '0;
      end
   end

endmodule // odl_loader
`default_nettype wire

// file: bench/odl_loader_properties.sv
// Purpose: port checks of the serial loader
// Assumes: core_clk domain only
// Notes:   bound onto odl_loader
`timescale 1ns/100ps
`default_nettype none
module odl_loader_properties
(
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic        sclk,
   input wire logic        load_select_n,
   input wire logic        serial_word_in,
   input wire logic        midscale_reset_n,
   input wire logic        power_down_n,
   input wire logic [63:0] channel_latch,
   input wire logic [63:0] channel_output,
   input wire logic        powered_down,
   input wire logic [7:0]  channel_updated
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   logic [63:0] upd_m;
   always_comb
      for (int i = 0; i < 64; i++)
         upd_m[i] = channel_updated[i/8];
   // ****
   // checks
   // ****
   sequence word_done;
      $rose(load_select_n) && midscale_reset_n;
   endsequence
   load_lat_a: assert property (word_done |-> ##[4:9] (|channel_updated))
      else $error("no latch update after select rise");
   mid_force_a: assert property (!midscale_reset_n [*6] |-> channel_latch == {8{8'h80}})
      else $error("latches not at mid-scale");
   mid_only_a: assert property ($changed(channel_latch) && channel_updated == 8'h00
      |-> channel_latch == {8{8'h80}})
      else $error("latch changed without a write");
   kept_others_a: assert property (|channel_updated
      |-> ((channel_latch ^ $past(channel_latch)) & ~upd_m) == 64'h0)
      else $error("unaddressed latch changed");
   run_out_a: assert property (!powered_down [*2] |-> channel_output == channel_latch)
      else $error("output differs from latch");
   pd_blank_a: assert property (powered_down [*2] |-> channel_output == 64'h0)
      else $error("output not blank in shutdown");
   pd_enter_a: assert property (!power_down_n [*6] |-> powered_down)
      else $error("shutdown not entered");
   pd_exit_a: assert property (power_down_n [*6] |-> !powered_down)
      else $error("shutdown not left");
endmodule // odl_loader_properties
bind odl_loader odl_loader_properties i_props (.core_clk(core_clk), .nrst(nrst), .sclk(sclk),
   .load_select_n(load_select_n), .serial_word_in(serial_word_in),
   .midscale_reset_n(midscale_reset_n), .power_down_n(power_down_n),
   .channel_latch(channel_latch), .channel_output(channel_output),
   .powered_down(powered_down), .channel_updated(channel_updated));
`default_nettype wire

// file: bench/odl_host_model.sv
// Purpose: three-wire host driving the loader
// Assumes: link period 160 ns
// Notes:   clock parks high between frames
`timescale 1ns/100ps
`default_nettype none
module odl_host_model
(
   output var logic sclk,
   output var logic load_select_n,
   output var logic serial_word_in
);
   initial
   begin
      sclk           = 1'b1;
      load_select_n  = 1'b1;
      serial_word_in = 1'b0;
   end
   task automatic send(input logic [15:0] w, input int n);
      #13;
      load_select_n = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         sclk = 1'b0;
         serial_word_in = w[i];
         #80;
         sclk = 1'b1;
         #80;
      end
      load_select_n = 1'b1;
      // hold over: data no longer valid
      serial_word_in = ~serial_word_in;
   endtask
endmodule // odl_host_model
`default_nettype wire

// file: bench/odl_loader_tb_top.sv
// Purpose: self-checking bench of the serial loader
// Assumes: host model drives the link
// Notes:   latch expected from written words
`timescale 1ns/100ps
`default_nettype none
module odl_loader_tb_top;
   logic        core_clk, nrst, midscale_reset_n, power_down_n;
   logic        sclk, load_select_n, serial_word_in, powered_down;
   logic [63:0] channel_latch, channel_output, exp_latch;
   logic [7:0]  channel_updated;
   int          errors, checks;
   odl_host_model i_odl_host_model (.sclk(sclk), .load_select_n(load_select_n),
      .serial_word_in(serial_word_in));
   odl_loader i_odl_loader (.core_clk(core_clk), .nrst(nrst), .sclk(sclk),
      .load_select_n(load_select_n), .serial_word_in(serial_word_in),
      .midscale_reset_n(midscale_reset_n), .power_down_n(power_down_n),
      .channel_latch(channel_latch), .channel_output(channel_output),
      .powered_down(powered_down), .channel_updated(channel_updated));
   initial core_clk = 1'b0;
   always #4 core_clk = ~core_clk;
   task automatic cmp(input string what, input logic [63:0] e, input logic [63:0] g);
      checks++;
      if (g !== e)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // 12 cycles covers the 6-7 cycle apply plus sync spacing
   task automatic write(input logic [15:0] w, input int n);
      i_odl_host_model.send(w, n);
      wait_clk(12);
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_each_channel;
      logic [7:0] code;
      for (int a = 7; a >= 0; a--)
      begin
         code = 8'hff - 8'(a) * 8'h24;
         write({5'h00, 3'(a), code}, 11);
         exp_latch[a*8 +: 8] = code;
         cmp("latch", exp_latch, channel_latch);
      end
      $display("test each_channel done");
   endtask
   task automatic t_long_word;
      write({5'h16, 3'h5, 8'h3c}, 16);
      exp_latch[47:40] = 8'h3c;
      cmp("latch", exp_latch, channel_latch);
      $display("test long_word done");
   endtask
   task automatic t_shutdown;
      power_down_n = 1'b0;
      wait_clk(8);
      cmp("output", 64'h0, channel_output);
      cmp("powered_down", 64'h1, 64'(powered_down));
      cmp("latch", exp_latch, channel_latch);
      power_down_n = 1'b1;
      wait_clk(8);
      cmp("output", exp_latch, channel_output);
      cmp("powered_down", 64'h0, 64'(powered_down));
      $display("test shutdown done");
   endtask
   task automatic t_mid_reset;
      midscale_reset_n = 1'b0;
      wait_clk(8);
      midscale_reset_n = 1'b1;
      wait_clk(4);
      exp_latch = {8{8'h80}};
      cmp("latch", exp_latch, channel_latch);
      $display("test mid_reset done");
   endtask
   initial
   begin
      nrst             = 1'b1;
      midscale_reset_n = 1'b1;
      power_down_n     = 1'b1;
      errors           = 0;
      checks           = 0;
      exp_latch        = {8{8'h80}};
      // a real falling edge, else the idle-clock shifter may never leave x
      #1;
      nrst             = 1'b0;
      wait_clk(4);
      nrst = 1'b1;
      wait_clk(2);
      cmp("latch", exp_latch, channel_latch);
      $display("test power_up done");
      t_each_channel;
      t_long_word;
      t_shutdown;
      t_mid_reset;
      tally_and_finish;
   end
   initial
   begin
      #200000;
      errors++;
      tally_and_finish;
   end
endmodule // odl_loader_tb_top
`default_nettype wire
